//--- src/ccs_pkg.sv
// Shared constants and types of the connection close services block.
// Assumes a single 125 MHz clock domain.
package ccs_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYCLES =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Disconnect service responses
    localparam logic [0:0] RSP_GOOD = 1'h0;
    localparam logic [0:0] RSP_INVALID_STATE = 1'h1;

    // Per-connection state
    typedef enum logic [1:0] {
        CONN_IDLE    = 2'b00,
        CONN_OPEN    = 2'b01,
        CONN_CLOSING = 2'b10,
        CONN_REMOTE  = 2'b11
    } ccs_conn_type;

    // Close reasons, one code space for both close reports
    typedef enum logic [2:0] {
        RSN_DISCONNECT_REQUESTED = 3'b000,
        RSN_SENSE_DEASSERTED     = 3'b001,
        RSN_LOSS_OF_SIGNAL       = 3'b010,
        RSN_CONNECTION_REFUSED   = 3'b011,
        RSN_CLOSED_STATE         = 3'b100,
        RSN_CONNECTION_LOST      = 3'b101
    } ccs_reason_type;

    // Close report sequencer
    typedef enum logic [0:0] {
        REP_SCAN = 1'b0,
        REP_READ = 1'b1
    } ccs_rep_type;

endpackage : ccs_pkg

//--- src/ccs_sess_mem.sv
// Session identifier store, one entry per connection.
// Assumes one write and one read per cycle; read data is registered.
`timescale 1ns/1ps
`default_nettype none

module ccs_sess_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8,
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read port
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem_reg[rd_addr_i];
        end
    end

endmodule : ccs_sess_mem

`default_nettype wire

//--- src/ccs_close.sv
// Connection layer close services: disconnect, immediate disconnect,
// close reports, sense and loss-of-signal closes, port reset line.
// Assumes request inputs come from link-layer logic on clk_i; the sense
// and loss-of-signal pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Received count may be below requested buffer size.
// - Accept disconnect request and close the named connection.
// - Disconnect answers GOOD, or INVALID CONNECTION STATE if not established.
// - Immediate disconnect closes at once, drops data, sends no confirmation.
// - Disconnected confirmation on close and on failed connect.
// - Close reports wait until all received characters are delivered.
// - Drive device: sense line deassertion may raise remote disconnect.
// - Automation device: sense line deassertion may raise remote disconnect.
// - Ethernet loss of signal reports remote disconnect.
// - Disconnected carries session, connection and reason.
// - Remote disconnect carries session, connection and remote reason.
// - Automation device reset request resets port, asserts reset line.
// - After close a received confirmation may still deliver, maybe zero.
module ccs_close
    import ccs_pkg::*;
#(
    parameter int NCONN = 8,
    parameter int SESS_W = 8,
    parameter int CNT_W = 16,
    parameter bit IS_AUTOMATION = 1'b1,
    parameter bit SENSE_CLOSE_EN = 1'b1,
    parameter bit LOS_CLOSE_EN = 1'b1,
    parameter int CW = (NCONN > 1) ? $clog2(NCONN) : 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Physical pins
    input wire logic sense_i,
    input wire logic los_i,
    output logic port_reset_line_o,
    // Events from the transport below
    input wire logic est_valid_i,
    input wire logic [CW-1:0] est_conn_i,
    input wire logic [SESS_W-1:0] est_session_i,
    input wire logic fail_valid_i,
    input wire logic [CW-1:0] fail_conn_i,
    input wire logic [SESS_W-1:0] fail_session_i,
    input wire logic tcp_close_valid_i,
    input wire logic [CW-1:0] tcp_close_conn_i,
    input wire logic tcp_close_lost_i,
    input wire logic rx_char_valid_i,
    input wire logic [CW-1:0] rx_char_conn_i,
    // Close command to the transport below
    output logic net_close_valid_o,
    output logic [CW-1:0] net_close_conn_o,
    // Receive request and received confirmation
    input wire logic rcv_req_valid_i,
    input wire logic [CW-1:0] rcv_req_conn_i,
    input wire logic [CNT_W-1:0] rcv_req_size_i,
    output logic rcv_cfm_valid_o,
    output logic [CW-1:0] rcv_cfm_conn_o,
    output logic [CNT_W-1:0] rcv_cfm_count_o,
    // Disconnect and immediate disconnect requests
    input wire logic disc_req_valid_i,
    input wire logic [CW-1:0] disc_req_conn_i,
    output logic disc_rsp_valid_o,
    output logic [0:0] disc_rsp_code_o,
    input wire logic dimm_req_valid_i,
    input wire logic [CW-1:0] dimm_req_conn_i,
    // Port reset request
    input wire logic port_reset_req_i,
    // Close reports
    output logic disconnected_valid_o,
    output logic disc_received_valid_o,
    output logic [SESS_W-1:0] rep_session_o,
    output logic [CW-1:0] rep_conn_o,
    output ccs_reason_type rep_reason_o
);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [15:0] RST_CYC = 16'(RESET_PULSE_CYCLES);

    typedef struct packed {
        logic sense_meta;
        logic sense_sync;
        logic sense_prev;
        logic los_meta;
        logic los_sync;
        logic los_prev;
        ccs_conn_type [NCONN-1:0] st;
        ccs_reason_type [NCONN-1:0] rsn;
        logic [NCONN-1:0][CNT_W-1:0] pend;
        ccs_rep_type rep_st;
        logic [CW-1:0] rep_sel;
        logic [15:0] rst_cnt;
        logic rst_line;
        logic net_close_valid;
        logic [CW-1:0] net_close_conn;
        logic rcv_valid;
        logic [CW-1:0] rcv_conn;
        logic [CNT_W-1:0] rcv_count;
        logic disc_rsp_valid;
        logic [0:0] disc_rsp_code;
        logic dcfm_valid;
        logic drcv_valid;
        logic [SESS_W-1:0] rep_session;
        logic [CW-1:0] rep_conn;
        ccs_reason_type rep_reason;
    } ccs_state_type;

    ccs_state_type state_reg;
    ccs_state_type state_next;

    logic mem_wr_en;
    logic [CW-1:0] mem_wr_addr;
    logic [SESS_W-1:0] mem_wr_data;
    logic [CW-1:0] mem_rd_addr;
    logic [SESS_W-1:0] mem_rd_data;

    ccs_sess_mem #(
        .DEPTH(NCONN),
        .WIDTH(SESS_W),
        .AW(CW)
    ) u_sess_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(mem_wr_en),
        .wr_addr_i(mem_wr_addr),
        .wr_data_i(mem_wr_data),
        .rd_addr_i(mem_rd_addr),
        .rd_data_o(mem_rd_data)
    );

    always_comb begin
        logic sense_fall;
        logic los_rise;
        logic found;
        logic port_reset;
        logic [CNT_W-1:0] take;
        logic [CNT_W-1:0] inc;
        sense_fall = 1'b0;
        los_rise = 1'b0;
        found = 1'b0;
        port_reset = 1'b0;
        take = '0;
        inc = '0;
        state_next = state_reg;
        mem_wr_en = 1'b0;
        mem_wr_addr = est_conn_i;
        mem_wr_data = est_session_i;
        mem_rd_addr = state_reg.rep_sel;
        state_next.net_close_valid = 1'b0;
        state_next.rcv_valid = 1'b0;
        state_next.disc_rsp_valid = 1'b0;
        state_next.dcfm_valid = 1'b0;
        state_next.drcv_valid = 1'b0;

        // Pin synchronisers and edge detection on the second stage
        state_next.sense_meta = sense_i;
        state_next.sense_sync = state_reg.sense_meta;
        state_next.sense_prev = state_reg.sense_sync;
        state_next.los_meta = los_i;
        state_next.los_sync = state_reg.los_meta;
        state_next.los_prev = state_reg.los_sync;
        sense_fall = SENSE_CLOSE_EN & state_reg.sense_prev
            & ~state_reg.sense_sync;
        los_rise = LOS_CLOSE_EN & ~state_reg.los_prev & state_reg.los_sync;

        if (state_reg.rst_cnt != '0) begin
            state_next.rst_cnt = state_reg.rst_cnt - 16'h0001;
        end
        state_next.rst_line = (state_next.rst_cnt != '0);
        if (IS_AUTOMATION && port_reset_req_i) begin
            port_reset = 1'b1;
            state_next.rst_cnt = RST_CYC;
            state_next.rst_line = 1'b1;
        end

        // received count is min of pending and buffer size
        if (rcv_req_valid_i) begin
            if (state_reg.pend[rcv_req_conn_i] < rcv_req_size_i) begin
                take = state_reg.pend[rcv_req_conn_i];
            end else begin
                take = rcv_req_size_i;
            end
            state_next.rcv_valid = 1'b1;
            state_next.rcv_conn = rcv_req_conn_i;
            state_next.rcv_count = take;
        end

        if (disc_req_valid_i) begin
            state_next.disc_rsp_valid = 1'b1;
            if (state_reg.st[disc_req_conn_i] == CONN_OPEN) begin
                state_next.disc_rsp_code = RSP_GOOD;
            end else begin
                state_next.disc_rsp_code = RSP_INVALID_STATE;
            end
        end

        for (int i = 0; i < NCONN; i++) begin
            inc = '0;
            if (rx_char_valid_i && rx_char_conn_i == CW'(i)
                    && state_reg.st[i] != CONN_IDLE
                    && state_reg.pend[i] != CNT_MAX) begin
                inc = {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (rcv_req_valid_i && rcv_req_conn_i == CW'(i)) begin
                state_next.pend[i] = state_reg.pend[i] - take + inc;
            end else begin
                state_next.pend[i] = state_reg.pend[i] + inc;
            end
            if (est_valid_i && est_conn_i == CW'(i)) begin
                state_next.st[i] = CONN_OPEN;
                state_next.pend[i] = '0;
            end
            if (fail_valid_i && fail_conn_i == CW'(i)
                    && !(est_valid_i && est_conn_i == CW'(i))) begin
                state_next.st[i] = CONN_CLOSING;
                state_next.rsn[i] = RSN_CONNECTION_REFUSED;
            end
            if (state_reg.st[i] == CONN_OPEN) begin
                if (tcp_close_valid_i && tcp_close_conn_i == CW'(i)) begin
                    state_next.st[i] = CONN_REMOTE;
                    state_next.rsn[i] = tcp_close_lost_i
                        ? RSN_CONNECTION_LOST : RSN_CLOSED_STATE;
                end
                if (sense_fall) begin
                    state_next.st[i] = CONN_REMOTE;
                    state_next.rsn[i] = RSN_SENSE_DEASSERTED;
                end
                if (los_rise) begin
                    state_next.st[i] = CONN_REMOTE;
                    state_next.rsn[i] = RSN_LOSS_OF_SIGNAL;
                end
                if (disc_req_valid_i && disc_req_conn_i == CW'(i)) begin
                    state_next.st[i] = CONN_CLOSING;
                    state_next.rsn[i] = RSN_DISCONNECT_REQUESTED;
                end
            end
            // immediate close or port reset, data dropped, nothing reported
            if ((dimm_req_valid_i && dimm_req_conn_i == CW'(i))
                    || port_reset) begin
                state_next.st[i] = CONN_IDLE;
                state_next.pend[i] = '0;
            end
        end

        if (est_valid_i) begin
            mem_wr_en = 1'b1;
        end else if (fail_valid_i) begin
            mem_wr_en = 1'b1;
            mem_wr_addr = fail_conn_i;
            mem_wr_data = fail_session_i;
        end

        if (dimm_req_valid_i) begin
            state_next.net_close_valid = 1'b1;
            state_next.net_close_conn = dimm_req_conn_i;
        end else if (disc_req_valid_i
                && state_reg.st[disc_req_conn_i] == CONN_OPEN) begin
            state_next.net_close_valid = 1'b1;
            state_next.net_close_conn = disc_req_conn_i;
        end

        case (state_reg.rep_st)
            REP_SCAN: begin
                for (int i = 0; i < NCONN; i++) begin
                    if (!found && state_reg.pend[i] == '0
                            && (state_reg.st[i] == CONN_CLOSING
                            || state_reg.st[i] == CONN_REMOTE)) begin
                        found = 1'b1;
                        mem_rd_addr = CW'(i);
                        state_next.rep_sel = CW'(i);
                    end
                end
                if (found && !port_reset) begin
                    state_next.rep_st = REP_READ;
                end
            end
            REP_READ: begin
                state_next.rep_st = REP_SCAN;
                // report if still drained and not dropped
                if (state_reg.pend[state_reg.rep_sel] == '0
                        && state_next.pend[state_reg.rep_sel] == '0
                        && state_next.st[state_reg.rep_sel]
                        == state_reg.st[state_reg.rep_sel]
                        && state_reg.st[state_reg.rep_sel] != CONN_IDLE
                        && state_reg.st[state_reg.rep_sel] != CONN_OPEN
                        && !(est_valid_i && est_conn_i == state_reg.rep_sel)
                        && !(fail_valid_i
                        && fail_conn_i == state_reg.rep_sel)) begin
                    state_next.dcfm_valid =
                        (state_reg.st[state_reg.rep_sel] == CONN_CLOSING);
                    state_next.drcv_valid =
                        (state_reg.st[state_reg.rep_sel] == CONN_REMOTE);
                    state_next.rep_session = mem_rd_data;
                    state_next.rep_conn = state_reg.rep_sel;
                    state_next.rep_reason = state_reg.rsn[state_reg.rep_sel];
                    state_next.st[state_reg.rep_sel] = CONN_IDLE;
                end
            end
            default: begin
                state_next.rep_st = REP_SCAN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign port_reset_line_o = state_reg.rst_line;
    assign net_close_valid_o = state_reg.net_close_valid;
    assign net_close_conn_o = state_reg.net_close_conn;
    assign rcv_cfm_valid_o = state_reg.rcv_valid;
    assign rcv_cfm_conn_o = state_reg.rcv_conn;
    assign rcv_cfm_count_o = state_reg.rcv_count;
    assign disc_rsp_valid_o = state_reg.disc_rsp_valid;
    assign disc_rsp_code_o = state_reg.disc_rsp_code;
    assign disconnected_valid_o = state_reg.dcfm_valid;
    assign disc_received_valid_o = state_reg.drcv_valid;
    assign rep_session_o = state_reg.rep_session;
    assign rep_conn_o = state_reg.rep_conn;
    assign rep_reason_o = state_reg.rep_reason;

endmodule : ccs_close

`default_nettype wire

//--- sim/ccs_link_model.sv
// Link layer model that drains received characters through receives.
// Assumes the bench holds conn_i and size_i steady while go_i is high.
`timescale 1ns/1ps
`default_nettype none

module ccs_link_model #(
    parameter int CW = 3,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control from the bench
    input wire logic go_i,
    input wire logic [CW-1:0] conn_i,
    input wire logic [CNT_W-1:0] size_i,
    output logic [CNT_W-1:0] got_o,
    // Receive service toward the block
    output logic rcv_req_valid_o,
    output logic [CW-1:0] rcv_req_conn_o,
    output logic [CNT_W-1:0] rcv_req_size_o,
    input wire logic rcv_cfm_valid_i,
    input wire logic [CNT_W-1:0] rcv_cfm_count_i
);
    logic busy;
    logic done;

    // Idle request fields show the inverse so stale values never match
    assign rcv_req_conn_o = rcv_req_valid_o ? conn_i : ~conn_i;
    assign rcv_req_size_o = rcv_req_valid_o ? size_i : ~size_i;

    // drain until a short count, one receive outstanding
    always @(posedge clk_i) begin
        rcv_req_valid_o <= 1'b0;
        if (rst_i) begin
            busy <= 1'b0;
            done <= 1'b0;
            got_o <= '0;
        end else if (rcv_cfm_valid_i) begin
            busy <= 1'b0;
            done <= (rcv_cfm_count_i < size_i);
            got_o <= got_o + rcv_cfm_count_i;
        end else if (!go_i) begin
            done <= 1'b0;
        end else if (!busy && !done && !rcv_req_valid_o) begin
            rcv_req_valid_o <= 1'b1;
            busy <= 1'b1;
        end
    end
endmodule : ccs_link_model

`default_nettype wire

//--- sim/ccs_close_props.sv
// Concurrent checks on the ports of the close services block.
// Assumes it is bound into ccs_close with its parameters handed on.
`timescale 1ns/1ps
`default_nettype none

module ccs_close_props
    import ccs_pkg::*;
#(
    parameter int SESS_W = 8,
    parameter int CNT_W = 16,
    parameter int CW = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Requests
    input wire logic port_reset_req_i,
    input wire logic disc_req_valid_i,
    input wire logic dimm_req_valid_i,
    input wire logic [CW-1:0] dimm_req_conn_i,
    input wire logic rcv_req_valid_i,
    input wire logic [CW-1:0] rcv_req_conn_i,
    input wire logic [CNT_W-1:0] rcv_req_size_i,
    // Answers
    input wire logic port_reset_line_o,
    input wire logic net_close_valid_o,
    input wire logic [CW-1:0] net_close_conn_o,
    input wire logic disc_rsp_valid_o,
    input wire logic [0:0] disc_rsp_code_o,
    input wire logic rcv_cfm_valid_o,
    input wire logic [CW-1:0] rcv_cfm_conn_o,
    input wire logic [CNT_W-1:0] rcv_cfm_count_o,
    input wire logic disconnected_valid_o,
    input wire logic disc_received_valid_o,
    input wire ccs_reason_type rep_reason_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_disc_answer: assert property (
        disc_req_valid_i |=> disc_rsp_valid_o) else $error("no disc answer");
    a_rsp_cause: assert property (
        disc_rsp_valid_o |-> $past(disc_req_valid_i))
        else $error("disc answer without request");
    a_good_closes: assert property (
        disc_rsp_valid_o && disc_rsp_code_o == RSP_GOOD |-> net_close_valid_o)
        else $error("good answer without close");
    a_dimm_close: assert property (
        dimm_req_valid_i |=> net_close_valid_o
        && net_close_conn_o == $past(dimm_req_conn_i))
        else $error("immediate close missing");
    a_rcv_answer: assert property (
        rcv_req_valid_i |=> rcv_cfm_valid_o
        && rcv_cfm_conn_o == $past(rcv_req_conn_i))
        else $error("receive answer missing");
    a_rcv_bound: assert property (
        rcv_cfm_valid_o |-> rcv_cfm_count_o <= $past(rcv_req_size_i))
        else $error("count above buffer size");
    a_cfm_reason: assert property (
        disconnected_valid_o |-> !disc_received_valid_o && rep_reason_o inside
        {RSN_DISCONNECT_REQUESTED, RSN_SENSE_DEASSERTED, RSN_LOSS_OF_SIGNAL,
        RSN_CONNECTION_REFUSED}) else $error("bad confirmation reason");
    a_ind_reason: assert property (
        disc_received_valid_o |-> rep_reason_o inside {RSN_CLOSED_STATE,
        RSN_SENSE_DEASSERTED, RSN_LOSS_OF_SIGNAL, RSN_CONNECTION_LOST})
        else $error("bad indication reason");
    a_rep_spacing: assert property (
        disconnected_valid_o || disc_received_valid_o
        |=> !(disconnected_valid_o || disc_received_valid_o))
        else $error("reports back to back");
    a_reset_line: assert property (
        port_reset_req_i |=> port_reset_line_o [*8])
        else $error("reset line not held");
    a_line_cause: assert property (
        $rose(port_reset_line_o) |-> $past(port_reset_req_i))
        else $error("reset line without request");

    cover property (disconnected_valid_o);
    cover property (disc_received_valid_o);
    cover property (rcv_cfm_valid_o && rcv_cfm_count_o == '0);
endmodule : ccs_close_props

bind ccs_close ccs_close_props #(.SESS_W(SESS_W), .CNT_W(CNT_W), .CW(CW))
    i_ccs_close_props (.clk_i, .rst_i, .port_reset_req_i, .disc_req_valid_i,
    .dimm_req_valid_i, .dimm_req_conn_i, .rcv_req_valid_i, .rcv_req_conn_i,
    .rcv_req_size_i, .port_reset_line_o, .net_close_valid_o,
    .net_close_conn_o, .disc_rsp_valid_o, .disc_rsp_code_o, .rcv_cfm_valid_o,
    .rcv_cfm_conn_o, .rcv_cfm_count_o, .disconnected_valid_o,
    .disc_received_valid_o, .rep_reason_o);

`default_nettype wire

//--- sim/tb_ccs_close.sv
// Self-checking bench for the close services block.
// Assumes default parameters: 8 connections, 8-bit sessions, 16-bit counts.
`timescale 1ns/1ps
`default_nettype none

module tb_ccs_close;
    import ccs_pkg::*;
    logic clk_i, rst_i, sense_i, los_i, est_valid_i, fail_valid_i;
    logic tcp_close_valid_i, tcp_close_lost_i, rx_char_valid_i;
    logic disc_req_valid_i, dimm_req_valid_i, port_reset_req_i, go;
    logic port_reset_line_o, net_close_valid_o, rcv_req_valid_i;
    logic rcv_cfm_valid_o, disc_rsp_valid_o;
    logic disconnected_valid_o, disc_received_valid_o;
    logic [2:0] est_conn_i, fail_conn_i, tcp_close_conn_i, rx_char_conn_i;
    logic [2:0] disc_req_conn_i, dimm_req_conn_i, rcv_req_conn_i, gconn;
    logic [2:0] net_close_conn_o, rcv_cfm_conn_o, rep_conn_o;
    logic [7:0] est_session_i, fail_session_i, rep_session_o;
    logic [15:0] rcv_req_size_i, rcv_cfm_count_o, gsize, got, g0;
    logic [0:0] disc_rsp_code_o;
    ccs_reason_type rep_reason_o;
    int failures, checks_done, n;

    ccs_close i_ccs_close (.clk_i, .rst_i, .sense_i, .los_i,
        .port_reset_line_o, .est_valid_i, .est_conn_i, .est_session_i,
        .fail_valid_i, .fail_conn_i, .fail_session_i, .tcp_close_valid_i,
        .tcp_close_conn_i, .tcp_close_lost_i, .rx_char_valid_i,
        .rx_char_conn_i, .net_close_valid_o, .net_close_conn_o,
        .rcv_req_valid_i, .rcv_req_conn_i, .rcv_req_size_i, .rcv_cfm_valid_o,
        .rcv_cfm_conn_o, .rcv_cfm_count_o, .disc_req_valid_i,
        .disc_req_conn_i, .disc_rsp_valid_o, .disc_rsp_code_o,
        .dimm_req_valid_i, .dimm_req_conn_i, .port_reset_req_i,
        .disconnected_valid_o, .disc_received_valid_o, .rep_session_o,
        .rep_conn_o, .rep_reason_o);

    ccs_link_model i_ccs_link_model (.clk_i, .rst_i, .go_i(go),
        .conn_i(gconn), .size_i(gsize), .got_o(got),
        .rcv_req_valid_o(rcv_req_valid_i), .rcv_req_conn_o(rcv_req_conn_i),
        .rcv_req_size_o(rcv_req_size_i), .rcv_cfm_valid_i(rcv_cfm_valid_o),
        .rcv_cfm_count_i(rcv_cfm_count_o));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic final_report;
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic est(input logic [2:0] c, input logic [7:0] s);
        @(posedge clk_i);
        est_valid_i <= 1'b1;
        est_conn_i <= c;
        est_session_i <= s;
        @(posedge clk_i);
        est_valid_i <= 1'b0;
    endtask : est

    task automatic rx(input logic [2:0] c, input int k);
        @(posedge clk_i);
        rx_char_valid_i <= 1'b1;
        rx_char_conn_i <= c;
        repeat (k) @(posedge clk_i);
        rx_char_valid_i <= 1'b0;
    endtask : rx

    task automatic tcp(input logic [2:0] c, input logic lost);
        @(posedge clk_i);
        tcp_close_valid_i <= 1'b1;
        tcp_close_conn_i <= c;
        tcp_close_lost_i <= lost;
        @(posedge clk_i);
        tcp_close_valid_i <= 1'b0;
    endtask : tcp

    task automatic disc(input logic [2:0] c, input logic [0:0] code);
        @(posedge clk_i);
        disc_req_valid_i <= 1'b1;
        disc_req_conn_i <= c;
        @(posedge clk_i);
        disc_req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk("disc answer", {14'h0, 1'b1, code},
            {14'h0, disc_rsp_valid_o, disc_rsp_code_o});
        chk("close command", {15'h0, code == RSP_GOOD},
            {15'h0, net_close_valid_o});
        if (code == RSP_GOOD)
            chk("close conn", {13'h0, c}, {13'h0, net_close_conn_o});
    endtask : disc

    task automatic wait_rep(input logic k, input logic [2:0] c,
                            input logic [7:0] s, input ccs_reason_type r);
        @(negedge clk_i);
        for (n = 0; n < 100
             && !(disconnected_valid_o || disc_received_valid_o);
             n++) @(negedge clk_i);
        chk("report seen", 16'h1,
            {15'h0, disconnected_valid_o || disc_received_valid_o});
        chk("report kind", {15'h0, k}, {15'h0, disc_received_valid_o});
        chk("report conn", {13'h0, c}, {13'h0, rep_conn_o});
        chk("report session", {8'h0, s}, {8'h0, rep_session_o});
        chk("report reason", {13'h0, r}, {13'h0, rep_reason_o});
    endtask : wait_rep

    task automatic quiet(input int k);
        repeat (k) begin
            @(negedge clk_i);
            chk("no report", 16'h0,
                {15'h0, disconnected_valid_o || disc_received_valid_o});
        end
    endtask : quiet

    task automatic drain(input logic [2:0] c, input logic [15:0] sz);
        @(posedge clk_i);
        g0 = got;
        gconn <= c;
        gsize <= sz;
        go <= 1'b1;
    endtask : drain

    task automatic t_disc;
        est(3'h2, 8'h5a);
        disc(3'h2, RSP_GOOD);
        wait_rep(1'b0, 3'h2, 8'h5a, RSN_DISCONNECT_REQUESTED);
        disc(3'h3, RSP_INVALID_STATE);
        quiet(10);
        @(posedge clk_i);
        fail_valid_i <= 1'b1;
        fail_conn_i <= 3'h4;
        fail_session_i <= 8'h44;
        @(posedge clk_i);
        fail_valid_i <= 1'b0;
        wait_rep(1'b0, 3'h4, 8'h44, RSN_CONNECTION_REFUSED);
    endtask : t_disc

    task automatic t_hold;
        est(3'h1, 8'h11);
        rx(3'h1, 3);
        tcp(3'h1, 1'b0);
        quiet(20);
        drain(3'h1, 16'h2);
        wait_rep(1'b1, 3'h1, 8'h11, RSN_CLOSED_STATE);
        go <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("drained count", 16'h3, got - g0);
    endtask : t_hold

    task automatic t_dimm;
        est(3'h5, 8'h55);
        rx(3'h5, 2);
        @(posedge clk_i);
        dimm_req_valid_i <= 1'b1;
        dimm_req_conn_i <= 3'h5;
        @(posedge clk_i);
        dimm_req_valid_i <= 1'b0;
        @(negedge clk_i);
        chk("immediate close", 16'h000d, {12'h0, net_close_valid_o,
            net_close_conn_o});
        drain(3'h5, 16'h8);
        quiet(30);
        go <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("discarded count", 16'h0, got - g0);
    endtask : t_dimm

    task automatic t_remote;
        est(3'h0, 8'h20);
        sense_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        sense_i <= 1'b0;
        wait_rep(1'b1, 3'h0, 8'h20, RSN_SENSE_DEASSERTED);
        est(3'h6, 8'h66);
        los_i <= 1'b1;
        wait_rep(1'b1, 3'h6, 8'h66, RSN_LOSS_OF_SIGNAL);
        est(3'h7, 8'h77);
        los_i <= 1'b0;
        tcp(3'h7, 1'b1);
        wait_rep(1'b1, 3'h7, 8'h77, RSN_CONNECTION_LOST);
    endtask : t_remote

    task automatic t_reset;
        @(posedge clk_i);
        port_reset_req_i <= 1'b1;
        @(posedge clk_i);
        port_reset_req_i <= 1'b0;
        @(negedge clk_i);
        for (n = 0; port_reset_line_o === 1'b1 && n < 300; n++)
            @(negedge clk_i);
        chk("reset line cycles", 16'(RESET_PULSE_CYCLES), 16'(n));
    endtask : t_reset

    initial begin
        failures = 0;
        checks_done = 0;
        {rst_i, sense_i, los_i, est_valid_i, fail_valid_i, go} = 6'h20;
        {tcp_close_valid_i, tcp_close_lost_i, rx_char_valid_i} = 3'h0;
        {disc_req_valid_i, dimm_req_valid_i, port_reset_req_i} = 3'h0;
        {est_conn_i, fail_conn_i, tcp_close_conn_i, rx_char_conn_i} = 12'h0;
        {disc_req_conn_i, dimm_req_conn_i, gconn} = 9'h0;
        {est_session_i, fail_session_i, gsize} = 32'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_disc();
        t_hold();
        t_dimm();
        t_remote();
        t_reset();
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        final_report();
    end
endmodule : tb_ccs_close

`default_nettype wire
